// ==== dv/bbd_pwm_src.sv ====
// Dimming source standing in for the far side of the PWM input pin.
// Assumes a free-running system clock; the pin changes on falling edges.
`timescale 1ns/1ps
module bbd_pwm_src #(
	parameter int unsigned PERIOD = 64,
	parameter int unsigned HIGH = 16
) (
	input wire logic clk_sys,
	input wire logic full,
	output logic pwm_in
);
	int unsigned cnt = 0;

	// Period equals the window, so the high count per window is phase free
	// Full holds the pin high to reach the saturated duty
	always @(negedge clk_sys) begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		pwm_in <= full || (cnt < HIGH);
	end
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the backlight control and diagnostic registers.
// Assumes the strobe register port; inputs change on falling edges.
`timescale 1ns/1ps
module tb;
	import bbd_pkg::*;
	localparam int unsigned WB = 6;
	localparam int unsigned PH = 16;
	logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, driver_en = 0;
	logic pwm_in, reg_rvalid;
	logic [9:0] reg_addr = '0;
	logic [15:0] reg_wdata = '0, reg_rdata;
	bbd_main_t main_state = BBD_MS_OFF;
	logic [3:0] boost_step = '0;
	bbd_mon_t mon = '0;
	logic [5:0] short_mask = '0, supply_source, short_fault;
	logic [12:0] pin_mv [BBD_NOUT] = '{default: 13'h0};
	logic [12:0] short_level_mv;
	logic [12:0] thr [8] = '{13'd2600, 13'd3000, 13'd3400, 13'd3800,
		13'd4200, 13'd4800, 13'd5200, 13'd6000};
	bbd_main_t sts [9] = '{BBD_MS_OFF, BBD_MS_REG_START, BBD_MS_NV_READ,
		BBD_MS_STANDBY, BBD_MS_NORMAL, BBD_MS_DISCHARGE, BBD_MS_SHUTDOWN,
		BBD_MS_FAULT_REC, BBD_MS_ALL_FAIL};
	logic [4:0] cds [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h0D, 5'h0E, 5'h0F,
		5'h10, 5'h11};
	int miscompares = 0, cmp_count = 0;
	logic [5:0] exp_f;
	logic [15:0] exp_a;
	logic pwm_full = 1'b0;

	bbd_regs #(.WIN_BITS(WB)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .main_state(main_state),
		.boost_step(boost_step), .pwm_in(pwm_in), .mon(mon),
		.driver_en(driver_en), .short_mask(short_mask), .pin_mv(pin_mv),
		.supply_source(supply_source), .short_level_mv(short_level_mv),
		.short_fault(short_fault));
	bbd_pwm_src #(.PERIOD(64), .HIGH(PH)) host_pwm (.clk_sys(clk_sys),
		.full(pwm_full), .pwm_in(pwm_in));

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask

	// Read data is taken in the cycle where rvalid stands
	task automatic rd(input logic [9:0] a, input logic [15:0] e);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		chk("rvalid", 16'h0001, {15'h0, reg_rvalid});
		chk($sformatf("rdata %h", a), e, reg_rdata);
	endtask

	task automatic wrap_up;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		miscompares++;
		wrap_up();
	end

	initial begin
		repeat (6) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		rd(BBD_OFS_SUPPLY, 16'h01C0);
		rd(BBD_OFS_SHORT, 16'h2882);
		chk("level", 16'd4200, {3'h0, short_level_mv});
		wr(BBD_OFS_SUPPLY, 16'hA5C0);
		rd(BBD_OFS_SUPPLY, 16'hA5C0);
		chk("supply", 16'h0029, {10'h0, supply_source});
		for (int c = 0; c < 8; c++) begin
			// Even outputs sit exactly on the threshold, odd one above
			for (int i = 0; i < BBD_NOUT; i++) pin_mv[i] = thr[c] + 13'(i % 2);
			short_mask = 6'(c * 2);
			driver_en = (c != 5);
			wr(BBD_OFS_SHORT, 16'h2082 | 16'(c << 9));
			repeat (3) @(negedge clk_sys);
			chk("level", {3'h0, thr[c]}, {3'h0, short_level_mv});
			exp_f = driver_en ? 6'b101010 & ~short_mask : 6'h0;
			chk("fault", {10'h0, exp_f}, {10'h0, short_fault});
		end
		for (int k = 0; k < 9; k++) begin
			main_state = sts[k];
			rd(BBD_OFS_STATE, {11'h0, cds[k]});
		end
		main_state = BBD_MS_BOOST_START;
		for (int k = 0; k < 4; k++) begin
			boost_step = 4'(k * 5);
			rd(BBD_OFS_STATE, 16'(k < 2 ? 4 + k * 5 : 12));
		end
		mon.out_duty = 16'hC35A;
		mon.sink_dac = 12'hFFF;
		mon.boost_code = 11'h7FF;
		rd(BBD_OFS_OUT_DUTY, 16'hC35A);
		rd(BBD_OFS_SINK, 16'h0FFF);
		rd(BBD_OFS_BOOST, 16'h07FF);
		for (int v = 0; v < 8; v++) begin
			mon.dim_rate = 3'(v);
			mon.sw_rate = 3'(7 - v);
			mon.topology = 3'(v);
			exp_a = 16'((v << 6) | ((7 - v) << 3) | v);
			rd(BBD_OFS_AUTODET, exp_a);
		end
		wr(BBD_OFS_OUT_DUTY, 16'h0000);
		rd(BBD_OFS_OUT_DUTY, 16'hC35A);
		wr(BBD_OFS_STATE, 16'hFFFF);
		rd(BBD_OFS_STATE, 16'h000C);
		wr(10'h289, 16'hFFFF);
		rd(BBD_OFS_SUPPLY, 16'hA5C0);
		rd(10'h300, 16'h0000);
		repeat (200) @(negedge clk_sys);
		rd(BBD_OFS_IN_DUTY, 16'(PH) << (16 - WB));
		pwm_full = 1'b1;
		repeat (200) @(negedge clk_sys);
		rd(BBD_OFS_IN_DUTY, 16'hFFFF);
		wrap_up();
	end
endmodule

// ==== verilog/bbd_pkg.sv ====
// Package for the backlight boost and diagnostics register group.
// Assumes a 16-bit register port driven by the serial control front end.
package bbd_pkg;
	localparam int unsigned BBD_AW = 10;
	localparam int unsigned BBD_DW = 16;
	localparam int unsigned BBD_NOUT = 6;
	localparam logic [9:0] BBD_OFS_SUPPLY = 10'h288;
	localparam logic [9:0] BBD_OFS_SHORT = 10'h28A;
	localparam logic [9:0] BBD_OFS_STATE = 10'h2A4;
	localparam logic [9:0] BBD_OFS_IN_DUTY = 10'h2A6;
	localparam logic [9:0] BBD_OFS_OUT_DUTY = 10'h2A8;
	localparam logic [9:0] BBD_OFS_SINK = 10'h2AA;
	localparam logic [9:0] BBD_OFS_BOOST = 10'h2AC;
	localparam logic [9:0] BBD_OFS_AUTODET = 10'h2AE;
	localparam logic [15:0] BBD_RST_SUPPLY = 16'h01C0;
	localparam logic [15:0] BBD_RST_SHORT = 16'h2882;
	localparam int unsigned BBD_SUPPLY_LSB = 10;
	localparam int unsigned BBD_LEVEL_LSB = 9;
	localparam int unsigned BBD_RATE_LSB = 6;
	localparam int unsigned BBD_SWR_LSB = 3;
	localparam int unsigned BBD_TOPO_LSB = 0;
	localparam int unsigned BBD_PWM_WIN_BITS = 16;
	localparam logic [4:0] BBD_ST_REG_START = 5'h01;
	localparam logic [4:0] BBD_ST_NV_READ = 5'h02;
	localparam logic [4:0] BBD_ST_STANDBY = 5'h03;
	localparam logic [4:0] BBD_ST_BOOST_LO = 5'h04;
	localparam logic [4:0] BBD_ST_BOOST_HI = 5'h0C;
	localparam logic [4:0] BBD_ST_NORMAL = 5'h0D;
	localparam logic [4:0] BBD_ST_DISCHARGE = 5'h0E;
	localparam logic [4:0] BBD_ST_SHUTDOWN = 5'h0F;
	localparam logic [4:0] BBD_ST_FAULT_REC = 5'h10;
	localparam logic [4:0] BBD_ST_ALL_FAIL = 5'h11;
	// Short thresholds in millivolts, codes 0 to 7
	localparam logic [12:0] BBD_THR_MV [8] = '{13'd2600, 13'd3000,
		13'd3400, 13'd3800, 13'd4200, 13'd4800, 13'd5200, 13'd6000};

	typedef enum logic [3:0] {
		BBD_MS_OFF,
		BBD_MS_REG_START,
		BBD_MS_NV_READ,
		BBD_MS_STANDBY,
		BBD_MS_BOOST_START,
		BBD_MS_NORMAL,
		BBD_MS_DISCHARGE,
		BBD_MS_SHUTDOWN,
		BBD_MS_FAULT_REC,
		BBD_MS_ALL_FAIL
	} bbd_main_t;

	typedef struct packed {
		logic [15:0] out_duty;
		logic [11:0] sink_dac;
		logic [10:0] boost_code;
		logic [2:0] dim_rate;
		logic [2:0] sw_rate;
		logic [2:0] topology;
	} bbd_mon_t;
endpackage

// ==== verilog/bbd_regs.sv ====
// Control and diagnostic registers of the backlight driver.
// Assumes a synchronous register port from the serial interface logic,
// analog comparisons already digitised into millivolt codes.
// What this block does
// RQ1: Bits 15..10 choose boost (0) or external supply (1) per output.
// RQ2: Bits 11..9 pick one of eight short thresholds, 2.6 V to 6.0 V.
// RQ3: Short fault only while driver enabled and pin above threshold.
// RQ4: Bits 4..0 show the live main state code.
// RQ5: Boost startup shows codes 4 to 12.
// RQ6: PWM input duty measured and shown as 16 bits.
// RQ7: Applied output 0 duty code readable.
// RQ8: Output 0 sink DAC code in bits 11..0, upper bits zero.
// RQ9: Boost voltage code in bits 10..0, upper bits zero.
// RQ10: Per-output mask bit set suppresses short detection.
// RQ11: Auto-detect bits 8..6 give detected dimming rate.
// RQ12: Auto-detect bits 5..3 give detected switching rate.
// RQ13: Auto-detect bits 2..0 give detected string topology.
// RQ14: Writes to monitor registers ignored; host keeps reserved bits.
`timescale 1ns/1ps
module bbd_regs
	import bbd_pkg::*;
#(
	parameter int unsigned WIN_BITS = BBD_PWM_WIN_BITS
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [BBD_AW-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [BBD_DW-1:0] reg_wdata,
	output logic [BBD_DW-1:0] reg_rdata,
	output logic reg_rvalid,
	input wire bbd_main_t main_state,
	input wire logic [3:0] boost_step,
	input wire logic pwm_in,
	input wire bbd_mon_t mon,
	input wire logic driver_en,
	input wire logic [BBD_NOUT-1:0] short_mask,
	input wire logic [12:0] pin_mv [BBD_NOUT],
	output logic [BBD_NOUT-1:0] supply_source,
	output logic [12:0] short_level_mv,
	output logic [BBD_NOUT-1:0] short_fault
);
	typedef struct packed {
		logic [15:0] supply;
		logic [15:0] short_ctl;
		logic [15:0] rdata;
		logic rvalid;
		logic [4:0] state_code;
		logic [2:0] pwm_sync;
		logic pwm_lvl;
		logic [WIN_BITS-1:0] win_cnt;
		logic [WIN_BITS:0] hi_cnt;
		logic [15:0] in_duty;
		logic [BBD_NOUT-1:0] fault;
		logic [12:0] level_mv;
		logic [BBD_NOUT-1:0] src;
	} bbd_state_t;

	bbd_state_t s_q;
	bbd_state_t s_d;
	logic rst_meta_n_q;
	logic rst_n_q;
	logic win_end;

	function automatic logic [4:0] state_code(bbd_main_t st,
		logic [3:0] step);
		logic [4:0] code;
		code = 5'h00;
		case (st)
			BBD_MS_REG_START: code = BBD_ST_REG_START;
			BBD_MS_NV_READ: code = BBD_ST_NV_READ;
			BBD_MS_STANDBY: code = BBD_ST_STANDBY;
			BBD_MS_BOOST_START: begin
				// Step beyond the range saturates at the top code
				if ({1'b0, step} > BBD_ST_BOOST_HI - BBD_ST_BOOST_LO)
					code = BBD_ST_BOOST_HI;
				else
					code = BBD_ST_BOOST_LO + {1'b0, step};
			end
			BBD_MS_NORMAL: code = BBD_ST_NORMAL;
			BBD_MS_DISCHARGE: code = BBD_ST_DISCHARGE;
			BBD_MS_SHUTDOWN: code = BBD_ST_SHUTDOWN;
			BBD_MS_FAULT_REC: code = BBD_ST_FAULT_REC;
			BBD_MS_ALL_FAIL: code = BBD_ST_ALL_FAIL;
			default: code = 5'h00;
		endcase
		return code;
	endfunction

	// Release reset through two flops
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_n_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_n_q <= 1'b1;
			rst_n_q <= rst_meta_n_q;
		end
	end

	assign win_end = &s_q.win_cnt;

	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		if (reg_wr) begin
			// Only the two control words accept data [RQ14]
			if (reg_addr == BBD_OFS_SUPPLY)
				s_d.supply = reg_wdata; // [RQ1]
			if (reg_addr == BBD_OFS_SHORT)
				s_d.short_ctl = reg_wdata; // [RQ2]
		end
		// Read sees the old word if a write lands in the same cycle
		if (reg_rd) begin
			s_d.rvalid = 1'b1;
			case (reg_addr)
				BBD_OFS_SUPPLY: s_d.rdata = s_q.supply;
				BBD_OFS_SHORT: s_d.rdata = s_q.short_ctl;
				BBD_OFS_STATE: s_d.rdata = {11'h000, s_q.state_code}; // [RQ4]
				BBD_OFS_IN_DUTY: s_d.rdata = s_q.in_duty; // [RQ6]
				BBD_OFS_OUT_DUTY: s_d.rdata = mon.out_duty; // [RQ7]
				BBD_OFS_SINK: s_d.rdata = {4'h0, mon.sink_dac}; // [RQ8]
				BBD_OFS_BOOST: s_d.rdata = {5'h00, mon.boost_code}; // [RQ9]
				BBD_OFS_AUTODET: s_d.rdata = {7'h00, mon.dim_rate, // [RQ11]
					mon.sw_rate, mon.topology}; // [RQ12] [RQ13]
				default: s_d.rdata = 16'h0000;
			endcase
		end
		s_d.state_code = state_code(main_state, boost_step); // [RQ4] [RQ5]
		// Three flops on the pin; level moves when the last two agree
		s_d.pwm_sync = {s_q.pwm_sync[1:0], pwm_in};
		if (s_q.pwm_sync[2] == s_q.pwm_sync[1])
			s_d.pwm_lvl = s_q.pwm_sync[2];
		// High time over a fixed window, scaled to 16 bits [RQ6]
		s_d.win_cnt = s_q.win_cnt + 1'b1;
		if (win_end) begin
			if (s_q.hi_cnt[WIN_BITS])
				s_d.in_duty = 16'hFFFF;
			else
				s_d.in_duty = 16'(s_q.hi_cnt[WIN_BITS-1:0] << (16 - WIN_BITS));
			s_d.hi_cnt = {{WIN_BITS{1'b0}}, s_q.pwm_lvl};
		end else begin
			s_d.hi_cnt = s_q.hi_cnt + {{WIN_BITS{1'b0}}, s_q.pwm_lvl};
		end
		// Level is registered, so a new code bites one cycle later
		s_d.level_mv = BBD_THR_MV[s_q.short_ctl[BBD_LEVEL_LSB +: 3]]; // [RQ2]
		for (int i = 0; i < BBD_NOUT; i++) begin
			// Masked outputs never flag; comparison against the registered level
			s_d.fault[i] = driver_en && !short_mask[i] && // [RQ3] [RQ10]
				(pin_mv[i] > s_q.level_mv);
		end
		s_d.src = s_q.supply[BBD_SUPPLY_LSB +: BBD_NOUT]; // [RQ1]
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			s_q <= '0;
			s_q.supply <= BBD_RST_SUPPLY;
			s_q.short_ctl <= BBD_RST_SHORT;
			s_q.level_mv <= BBD_THR_MV[BBD_RST_SHORT[BBD_LEVEL_LSB +: 3]];
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign reg_rvalid = s_q.rvalid;
	assign supply_source = s_q.src;
	assign short_level_mv = s_q.level_mv;
	assign short_fault = s_q.fault;

	// Outputs settle one cycle after their inputs; supply_source and short_level_mv two cycles after the write
	AST_SUPPLY_WRITE: assert property (@(posedge clk_sys) // [RQ1]
		disable iff (!rst_n_q)
		reg_wr && reg_addr == BBD_OFS_SUPPLY |=> ##1
		supply_source == $past(reg_wdata[15:10], 2))
		else $error("supply source not taken from write");

	AST_LEVEL_MAP: assert property (@(posedge clk_sys) // [RQ2]
		disable iff (!rst_n_q)
		reg_wr && reg_addr == BBD_OFS_SHORT && reg_wdata[11:9] == 3'h5
		##1 !(reg_wr && reg_addr == BBD_OFS_SHORT) |=>
		short_level_mv == 13'd4800)
		else $error("threshold code 5 not 4.8 V");

	AST_FAULT_NEEDS_EN: assert property (@(posedge clk_sys) // [RQ3]
		disable iff (!rst_n_q)
		!driver_en |=> short_fault == '0)
		else $error("short fault with driver disabled");

	AST_MASK_BLOCKS: assert property (@(posedge clk_sys) // [RQ10]
		disable iff (!rst_n_q)
		short_mask != '0 |=> (short_fault & $past(short_mask)) == '0)
		else $error("masked output flagged short");

	AST_NORMAL_CODE: assert property (@(posedge clk_sys) // [RQ4]
		disable iff (!rst_n_q)
		main_state == BBD_MS_NORMAL ##1 reg_rd && reg_addr == BBD_OFS_STATE
		|=> reg_rvalid && reg_rdata == 16'h000D)
		else $error("normal state code wrong");

	AST_BOOST_RANGE: assert property (@(posedge clk_sys) // [RQ5]
		disable iff (!rst_n_q)
		main_state == BBD_MS_BOOST_START |=>
		s_q.state_code >= 5'h04 && s_q.state_code <= 5'h0C)
		else $error("boost startup code out of range");

	AST_DUTY_AT_WINDOW: assert property (@(posedge clk_sys) // [RQ6]
		disable iff (!rst_n_q)
		$changed(s_q.in_duty) |-> $past(win_end))
		else $error("input duty changed outside window end");

	AST_SINK_UPPER_ZERO: assert property (@(posedge clk_sys) // [RQ8]
		disable iff (!rst_n_q)
		reg_rd && reg_addr == BBD_OFS_SINK |=>
		reg_rvalid && reg_rdata[15:12] == 4'h0)
		else $error("sink monitor upper bits not zero");

	AST_BOOST_UPPER_ZERO: assert property (@(posedge clk_sys) // [RQ9]
		disable iff (!rst_n_q)
		reg_rd && reg_addr == BBD_OFS_BOOST |=> reg_rdata[15:11] == 5'h00)
		else $error("boost monitor upper bits not zero");

	AST_RO_WRITE_IGNORED: assert property (@(posedge clk_sys) // [RQ14]
		disable iff (!rst_n_q)
		reg_wr && reg_addr != BBD_OFS_SUPPLY && reg_addr != BBD_OFS_SHORT
		|=> $stable(s_q.supply) && $stable(s_q.short_ctl))
		else $error("write to monitor changed control");

	AST_SUPPLY_READBACK: assert property (@(posedge clk_sys) // [RQ1]
		disable iff (!rst_n_q)
		reg_wr && reg_addr == BBD_OFS_SUPPLY ##1 !reg_wr
		##1 reg_rd && !reg_wr && reg_addr == BBD_OFS_SUPPLY
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("supply word read back differs from write");

	AST_LEVEL_LOWEST: assert property (@(posedge clk_sys) // [RQ2]
		disable iff (!rst_n_q)
		reg_wr && reg_addr == BBD_OFS_SHORT && reg_wdata[11:9] == 3'h0
		##1 !(reg_wr && reg_addr == BBD_OFS_SHORT) |=>
		short_level_mv == BBD_THR_MV[0])
		else $error("threshold code 0 not 2.6 V");

	AST_LEVEL_HIGHEST: assert property (@(posedge clk_sys) // [RQ2]
		disable iff (!rst_n_q)
		reg_wr && reg_addr == BBD_OFS_SHORT && reg_wdata[11:9] == 3'h7
		##1 !(reg_wr && reg_addr == BBD_OFS_SHORT) |=>
		short_level_mv == BBD_THR_MV[7])
		else $error("threshold code 7 not 6.0 V");

	AST_FAULT_ABOVE: assert property (@(posedge clk_sys) // [RQ3]
		disable iff (!rst_n_q)
		driver_en && !short_mask[1] && pin_mv[1] > short_level_mv
		|=> short_fault[1])
		else $error("output above threshold not flagged");

	AST_FAULT_AT_LEVEL: assert property (@(posedge clk_sys) // [RQ3]
		disable iff (!rst_n_q)
		!(pin_mv[0] > short_level_mv) |=> !short_fault[0])
		else $error("output at threshold flagged short");

	AST_ALL_FAIL_CODE: assert property (@(posedge clk_sys) // [RQ4]
		disable iff (!rst_n_q)
		main_state == BBD_MS_ALL_FAIL |=> s_q.state_code == BBD_ST_ALL_FAIL)
		else $error("all outputs failed state code wrong");

	AST_BOOST_SATURATE: assert property (@(posedge clk_sys) // [RQ5]
		disable iff (!rst_n_q)
		main_state == BBD_MS_BOOST_START && boost_step > 4'h8 |=>
		s_q.state_code == BBD_ST_BOOST_HI)
		else $error("late boost step left startup range");

	AST_DUTY_FULL: assert property (@(posedge clk_sys) // [RQ6]
		disable iff (!rst_n_q)
		win_end && s_q.hi_cnt[WIN_BITS] |=> s_q.in_duty == 16'hFFFF)
		else $error("all high window not full scale");

	AST_OUT_DUTY_LIVE: assert property (@(posedge clk_sys) // [RQ7]
		disable iff (!rst_n_q)
		reg_rd && reg_addr == BBD_OFS_OUT_DUTY |=>
		reg_rdata == $past(mon.out_duty))
		else $error("output duty monitor not live");

	AST_AUTODET_RATE: assert property (@(posedge clk_sys) // [RQ11]
		disable iff (!rst_n_q)
		reg_rd && reg_addr == BBD_OFS_AUTODET |=> reg_rdata[15:9] == 7'h00
		&& reg_rdata[BBD_RATE_LSB +: 3] == $past(mon.dim_rate))
		else $error("dimming rate field wrong");

	AST_AUTODET_SWITCH: assert property (@(posedge clk_sys) // [RQ12]
		disable iff (!rst_n_q)
		reg_rd && reg_addr == BBD_OFS_AUTODET |=>
		reg_rdata[BBD_SWR_LSB +: 3] == $past(mon.sw_rate))
		else $error("switching rate field wrong");

	AST_AUTODET_TOPO: assert property (@(posedge clk_sys) // [RQ13]
		disable iff (!rst_n_q)
		reg_rd && reg_addr == BBD_OFS_AUTODET |=>
		reg_rdata[BBD_TOPO_LSB +: 3] == $past(mon.topology))
		else $error("string topology field wrong");

	COV_FAULT: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
		driver_en ##1 short_fault != '0);
	COV_BOOST_TOP: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
		s_q.state_code == 5'h0C);
	COV_FULL_DUTY: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
		s_q.in_duty == 16'hFFFF);
	COV_AUTODET_READ: cover property (@(posedge clk_sys)
		disable iff (!rst_n_q) reg_rd && reg_addr == BBD_OFS_AUTODET);
	COV_STEP_SATURATED: cover property (@(posedge clk_sys)
		disable iff (!rst_n_q) main_state == BBD_MS_BOOST_START && boost_step > 4'h8);
endmodule
